// ---- design/sss_port.sv ----
// Select-synchronised serial port slave with a classic Wishbone slave.
`timescale 1ns/1ps
`default_nettype none

module sss_port
    import sss_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        sck_i,
    input  wire logic        ss_n_i,
    input  wire logic        sdi_i,
    output logic             sdo_o,
    output logic             sdo_oe_o,
    input  wire logic        sleep_i,
    output logic             irq_o,
    output logic             wake_o
);

    // ------------------------------------------------------------
    // State and decoded terms.
    // ------------------------------------------------------------
    sss_state_t q;      // Registered state.
    sss_state_t n;      // Next state.
    logic       lead;   // Serial clock leaves its idle level.
    logic       trail;  // Serial clock returns to its idle level.
    logic       samp;   // Sampling edge of the serial clock.
    logic       shft;   // Output change edge of the serial clock.
    logic       slave;  // Port enabled in a slave mode.
    logic       hold;   // Serial logic held in reset.
    logic       bus_go; // Bus access completes this edge.
    logic [7:0] rx;     // Byte as it stands after a sample.

    // Edges of the synchronised serial clock, seen from clk_i.
    assign lead  = (q.sck_sy[1] ^ q.sck_old) & (q.sck_sy[1] != q.clock_idle_polarity);
    assign trail = (q.sck_sy[1] ^ q.sck_old) & (q.sck_sy[1] == q.clock_idle_polarity);
    // With the edge bit set data is taken on the leading edge.
    assign samp  = q.cke ? lead : trail;
    assign shft  = q.cke ? trail : lead;

    // Only the two slave codes run the shifter here.
    assign slave = q.en & ((q.mode == MODE_SS_ON)
                   | (q.mode == MODE_SS_OFF));
    // A disabled port, or a high select in the select-used mode, keeps the counter at zero.
    assign hold  = ~q.en
                 | ((q.mode == MODE_SS_ON) & q.ss_sy[1]);
    assign bus_go = wb_cyc_i & wb_stb_i & q.ack;
    assign rx     = {q.sr[6:0], q.sdi_sy[1]};

    // ------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------
    // The output is driven only while selected or with select unused.
    assign sdo_oe_o = slave & ~hold;
    assign sdo_o    = q.sdo;
    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.rdat;
    // One level interrupt from unmasked sticky events.
    assign irq_o    = |(q.ist & q.imsk);
    assign wake_o   = sleep_i & irq_o;

    // ------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------
    // Bus effects come first so that hardware events set afterwards
    // win over a clear in the same cycle.
    always_comb begin
        n = q;
        // Pins pass two flip-flops before anything reads them.
        n.sck_sy  = {q.sck_sy[0], sck_i};
        n.ss_sy   = {q.ss_sy[0], ss_n_i};
        n.sdi_sy  = {q.sdi_sy[0], sdi_i};
        n.sck_old = q.sck_sy[1];
        // Classic cycle: ack one cycle after the request, then drop.
        n.ack  = wb_cyc_i & wb_stb_i & ~q.ack;
        n.rdat = '0;
        if (wb_cyc_i && wb_stb_i && !q.ack) begin
            unique case (wb_adr_i)
                ADR_CON1: n.rdat[7:0] = {q.write_collision_flag, q.ov, q.en, q.clock_idle_polarity,
                                         q.mode};
                ADR_CON3: n.rdat[CON3_BUFFER_OVERWRITE_ENABLE] = q.buffer_overwrite_enable;
                ADR_STAT: n.rdat[7:0] = {q.input_sample_phase, q.cke, 5'h00, q.bf};
                ADR_BUF:  n.rdat[7:0] = q.dbuf;
                ADR_SSRT: n.rdat[ROUTE_W-1:0] = q.rt_ss;
                ADR_CKRT: n.rdat[ROUTE_W-1:0] = q.rt_ck;
                ADR_DTRT: n.rdat[ROUTE_W-1:0] = q.rt_dt;
                ADR_IST:  n.rdat[IST_W-1:0] = q.ist;
                ADR_IMSK: n.rdat[IST_W-1:0] = q.imsk;
                default:  n.rdat = '0;
            endcase
        end
        // Writes take effect at the edge where ack is high.
        if (bus_go && wb_we_i && wb_sel_i[0]) begin
            unique case (wb_adr_i)
                ADR_CON1: begin
                    n.write_collision_flag = wb_dat_i[CON1_WRITE_COLLISION_FLAG];
                    n.ov   = wb_dat_i[CON1_OV];
                    n.en   = wb_dat_i[CON1_EN];
                    n.clock_idle_polarity  = wb_dat_i[CON1_CKP];
                    n.mode = wb_dat_i[3:0];
                end
                ADR_CON3: n.buffer_overwrite_enable = wb_dat_i[CON3_BUFFER_OVERWRITE_ENABLE];
                ADR_STAT: begin
                    n.input_sample_phase = wb_dat_i[STAT_SMP];
                    n.cke = wb_dat_i[STAT_CKE];
                end
                ADR_BUF: begin
                    // A write mid byte or with a pending collision
                    // is refused and flagged.
                    if (q.cnt != 3'h0 || q.write_collision_flag) begin
                        n.write_collision_flag          = 1'b1;
                        n.ist[IST_WRITE_COLLISION_FLAG] = 1'b1;
                    end else begin
                        n.dbuf = wb_dat_i[7:0];
                        n.sr   = wb_dat_i[7:0];
                    end
                end
                ADR_SSRT: n.rt_ss = wb_dat_i[ROUTE_W-1:0];
                ADR_CKRT: n.rt_ck = wb_dat_i[ROUTE_W-1:0];
                ADR_DTRT: n.rt_dt = wb_dat_i[ROUTE_W-1:0];
                ADR_IST:  n.ist = q.ist & ~wb_dat_i[IST_W-1:0];
                ADR_IMSK: n.imsk = wb_dat_i[IST_W-1:0];
                default:  n.rdat = '0;
            endcase
        end
        // Reading the buffer empties it.
        if (bus_go && !wb_we_i && wb_adr_i == ADR_BUF) begin
            n.bf = 1'b0;
        end
        // Serial side. Master codes never shift here, asleep or awake;
        // sleep_i is not read, so slave codes keep shifting through sleep.
        if (hold) begin
            // Partial byte dropped; output waits with the top bit.
            n.cnt = 3'h0;
            n.sdo = n.sr[7];
        end else if (slave) begin
            // Steps come from serial clock edges only, not sleep_i.
            if (samp) begin
                n.sr  = rx;
                n.cnt = q.cnt + 3'h1;
                if (q.cnt == LAST_BIT) begin
                    // Completion reaches status in the clk_i domain.
                    n.ist[IST_DONE] = 1'b1;
                    if (!q.bf || q.buffer_overwrite_enable) begin
                        n.dbuf = rx;
                        n.bf   = 1'b1;
                    end else begin
                        n.ov          = 1'b1;
                        n.ist[IST_OV] = 1'b1;
                    end
                end
            end
            if (shft) begin
                n.sdo = q.sr[7];
            end
        end
    end

    // ------------------------------------------------------------
    // State register.
    // ------------------------------------------------------------
    // Synchronous reset loads the constant reset state.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= ST_RESET;
        end else begin
            q <= n;
        end
    end

    // ------------------------------------------------------------
    // Assertions and covers.
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ss_resets_cnt: assert property (
        q.en && q.mode == MODE_SS_ON && q.ss_sy[1] |=> q.cnt == 3'h0)
        else $error("Counter not cleared while select high.");

    a_en_resets_cnt: assert property (
        !q.en |=> q.cnt == 3'h0)
        else $error("Counter not cleared while disabled.");

    a_sdo_float: assert property (
        $rose(q.ss_sy[1]) && q.en && q.mode == MODE_SS_ON
        |-> !sdo_oe_o)
        else $error("Output still driven after select rose.");

    a_sdo_drive: assert property (
        q.en && q.mode == MODE_SS_ON && !q.ss_sy[1] |-> sdo_oe_o)
        else $error("Output not driven while selected.");

    a_mode_gate: assert property (
        q.mode != MODE_SS_ON && q.mode != MODE_SS_OFF |-> !sdo_oe_o)
        else $error("Output driven outside slave modes.");

    a_byte_done: assert property (
        slave && !hold && samp && q.cnt == LAST_BIT && !q.bf
        |=> q.bf && q.ist[IST_DONE] && q.dbuf == $past(rx))
        else $error("Completed byte not moved to buffer.");

    a_msb_first: assert property (
        slave && !hold && samp
        |=> q.sr == {$past(q.sr[6:0]), $past(q.sdi_sy[1])})
        else $error("Shift order wrong.");

    a_irq_level: assert property (
        $rose(q.ist[IST_DONE]) && q.imsk[IST_DONE] |-> irq_o ##1 irq_o)
        else $error("Interrupt missing after completion.");

    a_sync_delay: assert property (
        !$past(rst_i) && !$past(rst_i, 2)
        |-> q.ss_sy[1] == $past(ss_n_i, 2))
        else $error("Select not passed through two stages.");

    a_bus_ack: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("Bus ack not one cycle after request.");

    c_byte_done: cover property (slave && samp && q.cnt == LAST_BIT);
    c_collision: cover property ($rose(q.write_collision_flag));
    c_ss_abort:  cover property ($rose(q.ss_sy[1]) && q.cnt != 3'h0);

endmodule

`default_nettype wire

// ---- design/sss_pkg.sv ----
// Constants, register map and state type of the select-synchronised port.
package sss_pkg;

    // ------------------------------------------------------------
    // Register byte addresses on the bus.
    // ------------------------------------------------------------
    localparam logic [7:0] ADR_CON1 = 8'h00; // Control one.
    localparam logic [7:0] ADR_CON3 = 8'h04; // Control three.
    localparam logic [7:0] ADR_STAT = 8'h08; // Port state.
    localparam logic [7:0] ADR_BUF  = 8'h0C; // Data buffer.
    localparam logic [7:0] ADR_SSRT = 8'h10; // Select pin route.
    localparam logic [7:0] ADR_CKRT = 8'h14; // Clock pin route.
    localparam logic [7:0] ADR_DTRT = 8'h18; // Data pin route.
    localparam logic [7:0] ADR_IST  = 8'h1C; // Interrupt status.
    localparam logic [7:0] ADR_IMSK = 8'h20; // Interrupt mask.

    // ------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------
    localparam int CON1_WRITE_COLLISION_FLAG = 7; // Write collision flag.
    localparam int CON1_OV   = 6; // Receive overflow flag.
    localparam int CON1_EN   = 5; // Port enable.
    localparam int CON1_CKP  = 4; // Clock idle polarity.
    localparam int CON3_BUFFER_OVERWRITE_ENABLE = 4; // Buffer overwrite enable.
    localparam int STAT_SMP  = 7; // Input sample phase.
    localparam int STAT_CKE  = 6; // Clock edge select.
    localparam int STAT_BF   = 0; // Buffer full.
    localparam int IST_DONE  = 0; // Byte completed event.
    localparam int IST_WRITE_COLLISION_FLAG  = 1; // Write collision event.
    localparam int IST_OV    = 2; // Overflow event.

    // ------------------------------------------------------------
    // Mode codes, widths and counts.
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_SS_ON  = 4'h4; // Slave, select used.
    localparam logic [3:0] MODE_SS_OFF = 4'h5; // Slave, select unused.
    localparam int         ROUTE_W     = 5;    // Pin route width.
    localparam logic [2:0] LAST_BIT    = 3'h7; // Count at last bit.
    localparam int         IST_W       = 3;    // Event count.

    // Whole state of the port, registered in one place.
    typedef struct packed {
        logic [1:0]         sck_sy;  // Serial clock synchroniser.
        logic [1:0]         ss_sy;   // Select synchroniser.
        logic [1:0]         sdi_sy;  // Data input synchroniser.
        logic               sck_old; // Previous synchronised clock.
        logic               en;      // Port enable.
        logic               clock_idle_polarity;     // Clock idle polarity.
        logic [3:0]         mode;    // Port mode field.
        logic               input_sample_phase;     // Input sample phase.
        logic               cke;     // Clock edge select.
        logic               buffer_overwrite_enable;    // Buffer overwrite enable.
        logic               write_collision_flag;    // Write collision flag.
        logic               ov;      // Receive overflow flag.
        logic               bf;      // Buffer full.
        logic [7:0]         sr;      // Serial shift register.
        logic [7:0]         dbuf;    // Data buffer.
        logic [2:0]         cnt;     // Bit counter.
        logic               sdo;     // Serial data out level.
        logic [IST_W-1:0]   ist;     // Sticky event status.
        logic [IST_W-1:0]   imsk;    // Event mask.
        logic [ROUTE_W-1:0] rt_ss;   // Select pin route.
        logic [ROUTE_W-1:0] rt_ck;   // Clock pin route.
        logic [ROUTE_W-1:0] rt_dt;   // Data pin route.
        logic               ack;     // Bus acknowledge.
        logic [31:0]        rdat;    // Bus read data.
    } sss_state_t;

    // Reset value of the whole state.
    localparam sss_state_t ST_RESET = '0;

endpackage

// ---- tb/sss_master.sv ----
// Behavioural serial bus master that drives clock, select and data.
`timescale 1ns/1ps
`default_nettype none

module sss_master (
    output logic      sck_o,    // Serial clock, idles low.
    output logic      ss_n_o,   // Select, active low.
    output logic      sdi_o,    // Data towards the port.
    input  wire logic sdo_i,    // Data from the port.
    input  wire logic sdo_oe_i  // Port drives its data line.
);
    // ----------------------------------------------------------
    // Idle levels.
    // ----------------------------------------------------------
    initial begin
        sck_o  = 1'b0;
        ss_n_o = 1'b1;
        sdi_o  = 1'b0;
    end

    // Sends n bits of tx and gathers what the port sends back.
    // The clock runs only inside the frame; keep leaves select low.
    task automatic xfer(input logic [7:0] tx, input int n,
                        input bit use_ss, input bit keep,
                        output logic [7:0] rx);
        rx = 8'h00;
        // Step off the bus clock edge that the caller may return on.
        #3;
        if (use_ss) begin
            ss_n_o = 1'b0;
        end
        #200;
        for (int i = 7; i > 7 - n; i--) begin
            // Data moves mid low phase, clear of both clock edges.
            #40 sdi_o = tx[i];
            #40 sck_o = 1'b1;
            rx = {rx[6:0], sdo_oe_i ? sdo_i : 1'bx};
            #80 sck_o = 1'b0;
        end
        #160;
        if (!keep) begin
            ss_n_o = 1'b1;
        end
        // A released data line shows no stale value.
        sdi_o = ~sdi_o;
    endtask
endmodule

`default_nettype wire

// ---- tb/sss_port_tb.sv ----
// Self-checking bench for the select-synchronised serial port.
`timescale 1ns/1ps
`default_nettype none

module sss_port_tb import sss_pkg::*; ();
    logic        clk_i, rst_i, cyc, stb, we, sleep_i, ack;
    logic [7:0]  adr, rx;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, dat_o;
    logic        sck, ss_n, sdi, sdo, sdo_oe, irq, wake;
    int          fail_count  = 0;
    int          comparisons = 0;
    int          cycle_count = 0;

    sss_port dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .sck_i(sck), .ss_n_i(ss_n), .sdi_i(sdi), .sdo_o(sdo),
        .sdo_oe_o(sdo_oe), .sleep_i(sleep_i), .irq_o(irq),
        .wake_o(wake));

    sss_master m (.sck_o(sck), .ss_n_o(ss_n), .sdi_o(sdi),
        .sdo_i(sdo), .sdo_oe_i(sdo_oe));

    // ----------------------------------------------------------
    // Clock, timeout and verdict.
    // ----------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", comparisons,
                 fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // A hang counts as a mismatch and ends the run.
    always @(posedge clk_i) begin
        cycle_count <= cycle_count + 1;
        if (cycle_count == 30000) begin
            fail_count++;
            give_verdict();
        end
    end

    // ----------------------------------------------------------
    // Bus and compare helpers.
    // ----------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // One classic cycle; ack and read data are taken at the rising
    // edge where ack is high, and the request is released there.
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= {24'h000000, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        check(rdat, {24'h000000, e});
    endtask

    // Lets synchronisers and completion logic finish.
    task automatic settle;
        repeat (10) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    // ----------------------------------------------------------
    // Main sequence.
    // ----------------------------------------------------------
    initial begin
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h1;
        wdat = 32'h00000000;
        sleep_i = 1'b0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        check(sdo_oe, 32'h0);
        rd(ADR_CON1, 8'h00);
        rd(8'h24, 8'h00);
        // Full byte received while asleep, interrupt unmasked.
        wr(ADR_BUF, 8'hA5);
        wr(ADR_IMSK, 8'h01);
        wr(ADR_STAT, 8'h40);
        wr(ADR_CON1, 8'h24);
        sleep_i <= 1'b1;
        m.xfer(8'h3C, 8, 1, 0, rx);
        check(rx, 32'hA5);
        settle();
        check(sdo_oe, 32'h0);
        check(wake, 32'h1);
        check(irq, 32'h1);
        rd(ADR_STAT, 8'h41);
        rd(ADR_BUF, 8'h3C);
        rd(ADR_STAT, 8'h40);
        wr(ADR_IST, 8'h07);
        settle();
        check(irq, 32'h0);
        // Aborted frame, then a clean one.
        m.xfer(8'hFF, 3, 1, 0, rx);
        settle();
        rd(ADR_IST, 8'h00);
        m.xfer(8'h81, 8, 1, 0, rx);
        settle();
        rd(ADR_BUF, 8'h81);
        // Disable mid-frame with select still low; interrupt masked.
        wr(ADR_IST, 8'h07);
        wr(ADR_IMSK, 8'h00);
        m.xfer(8'h00, 5, 1, 1, rx);
        wr(ADR_CON1, 8'h04);
        wr(ADR_CON1, 8'h24);
        m.xfer(8'h5A, 8, 1, 0, rx);
        settle();
        check(wake, 32'h0);
        rd(ADR_IST, 8'h01);
        rd(ADR_BUF, 8'h5A);
        // Select left high: only the select-free mode receives.
        for (int k = 4; k < 6; k++) begin
            wr(ADR_IST, 8'h07);
            // Edge bit set only while select control is in use.
            wr(ADR_STAT, {1'b0, k == 4, 6'h00});
            wr(ADR_CON1, {4'h2, 4'(k)});
            m.xfer(8'hC3, 8, 0, 0, rx);
            settle();
            rd(ADR_IST, {7'h00, k == 5});
        end
        rd(ADR_BUF, 8'hC3);
        // A second byte with the buffer still full is lost and flagged.
        wr(ADR_IST, 8'h07);
        m.xfer(8'h11, 8, 0, 0, rx);
        m.xfer(8'h22, 8, 0, 0, rx);
        settle();
        rd(ADR_IST, 8'h05);
        rd(ADR_CON1, 8'h65);
        rd(ADR_BUF, 8'h11);
        // A buffer write in mid byte is refused and flagged.
        m.xfer(8'h00, 3, 0, 1, rx);
        wr(ADR_BUF, 8'h99);
        rd(ADR_CON1, 8'hE5);
        rd(ADR_IST, 8'h07);
        rd(ADR_BUF, 8'h11);
        wr(ADR_CON1, 8'h05);
        rd(ADR_CON1, 8'h05);
        // Pin routes are plain storage.
        for (int r = 0; r < 3; r++) begin
            wr(ADR_SSRT + 8'(4 * r), 8'(8'h11 + r));
            rd(ADR_SSRT + 8'(4 * r), 8'(8'h11 + r));
        end
        give_verdict();
    end
endmodule

`default_nettype wire
